// ---- hw/urxsf_pkg.sv ----
// Purpose: Constants and types for the receive status flag block.
// Assumes: APB register access, 32-bit data, byte addresses on paddr.
// Notes:   Operation list follows.
// Operation
// - Frame moved to data register sets receive-full.
// - Receive-full clears on seen status, then data.
// - Idle after 10 or 11 high bits.
// - Idle rearms only after a frame loads.
// - Idle clears on seen status, then data.
// - Wakeup bit blocks setting of idle.
// - Frame arriving while full sets overrun.
// - Overrun rises right after the stop bit.
// - Overrun drops new frame, keeps data register.
// - Overrun clears on seen status, then data.
// - Late overrun reads set with receive-full clear.
// - Noise during frame sets noise flag.
// - Error flags set with receive-full, not overrun.
// - Noise, parity clear on any status, data.
// - Low stop bit sets framing error.
// - Framing error blocks further reception.
// - Framing clears on seen status, then data.
// - Enabled parity mismatch sets parity error.
// - Word length gives 10 or 11 bit frames.
package urxsf_pkg;

  localparam logic [7:0] URXSF_STATUS_OFS  = 8'h00;
  localparam logic [7:0] URXSF_DATA_OFS    = 8'h04;
  localparam logic [7:0] URXSF_CTRL_OFS    = 8'h08;

  localparam int URXSF_FULL_BIT    = 5;
  localparam int URXSF_IDLE_BIT    = 4;
  localparam int URXSF_OVERRUN_BIT = 3;
  localparam int URXSF_NOISE_BIT   = 2;
  localparam int URXSF_FRAMING_BIT = 1;
  localparam int URXSF_PARITY_BIT  = 0;

  localparam int URXSF_WORD_BIT    = 0;
  localparam int URXSF_PEN_BIT     = 1;
  localparam int URXSF_PTYPE_BIT   = 2;
  localparam int URXSF_WAKE_BIT    = 3;

  localparam logic [7:0] URXSF_CTRL_RESET   = 8'h00;
  localparam logic [5:0] URXSF_STATUS_RESET = 6'h00;
  localparam logic [8:0] URXSF_DATA_RESET   = 9'h000;

  localparam logic [3:0] URXSF_IDLE_SHORT = 4'hA;
  localparam logic [3:0] URXSF_IDLE_LONG  = 4'hB;

  typedef enum logic [1:0] {
    APB_WAIT = 2'b01,
    APB_DONE = 2'b10
  } urxsf_apb_type;

endpackage

// ---- hw/urxsf_receive_status.sv ----
// Purpose: Receive status flags with status-then-data clearing over APB.
// Assumes: Sampler results and bit tick come from logic on clk.
// Notes:   The serial input pin is synchronised before the idle counter.
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ns
module urxsf_receive_status
  import urxsf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxPin,
  input  wire logic        bitTick,
  input  wire logic        frameDone,
  input  wire logic [8:0]  frameData,
  input  wire logic        frameNoise,
  input  wire logic        frameStopBit,
  output logic      [5:0]  statusFlags
);

  typedef struct packed {
    urxsf_apb_type apbState;
    logic          rxMeta;
    logic          rxLevel;
    logic [3:0]    idleCount;
    logic          idleArmed;
    logic          fullFlag;
    logic          idleFlag;
    logic          overrunFlag;
    logic          noiseFlag;
    logic          framingFlag;
    logic          parityFlag;
    logic          seenFull;
    logic          seenIdle;
    logic          seenOverrun;
    logic          seenFraming;
    logic          statusArmed;
    logic [8:0]    rxData;
    logic [7:0]    ctrl;
    logic [31:0]   rdata;
    logic          ready;
    logic          slverr;
    logic [5:0]    flagsOut;
  } urxsf_state_type;

  localparam urxsf_state_type STATE_RESET = '{
    apbState: APB_WAIT,
    rxMeta:   1'b1,
    rxLevel:  1'b1,
    rxData:   URXSF_DATA_RESET,
    ctrl:     URXSF_CTRL_RESET,
    flagsOut: URXSF_STATUS_RESET,
    default:  '0
  };

  // Index 3 marks an unmapped address.
  function automatic logic [1:0] regIndex(input logic [7:0] addr);
    logic [1:0] idx;
    idx = 2'h3;
    if (addr == URXSF_STATUS_OFS) begin
      idx = 2'h0;
    end else if (addr == URXSF_DATA_OFS) begin
      idx = 2'h1;
    end else if (addr == URXSF_CTRL_OFS) begin
      idx = 2'h2;
    end
    return idx;
  endfunction

  urxsf_state_type r;
  urxsf_state_type n;

  logic       wordLong;
  logic       parityEnable;
  logic       parityType;
  logic       wakeup;
  logic [3:0] idleLimit;
  logic       idleEvent;
  logic       frameAccept;
  logic       loadEvent;
  logic       overrunEvent;
  logic [8:0] parityBits;
  logic       parityBad;
  logic       apbDone;
  logic       statusRead;
  logic       dataRead;
  logic       ctrlWrite;
  logic       clearFull;
  logic       clearIdle;
  logic       clearOverrun;
  logic       clearFraming;
  logic       clearSoft;
  logic [5:0] flagsNow;

  always_comb begin
    wordLong     = r.ctrl[URXSF_WORD_BIT];
    parityEnable = r.ctrl[URXSF_PEN_BIT];
    parityType   = r.ctrl[URXSF_PTYPE_BIT];
    wakeup       = r.ctrl[URXSF_WAKE_BIT];

    // The idle character is one whole frame length of marks.
    idleLimit = wordLong ? URXSF_IDLE_LONG : URXSF_IDLE_SHORT;
    idleEvent = bitTick && r.rxLevel && (r.idleCount == idleLimit - 4'h1);

    // A pending framing error holds off every new frame.
    frameAccept  = frameDone && !r.framingFlag;
    loadEvent    = frameAccept && !r.fullFlag;
    overrunEvent = frameAccept && r.fullFlag;

    // The parity bit is the top data bit of the selected word length.
    parityBits = wordLong ? frameData : {1'b0, frameData[7:0]};
    parityBad  = parityEnable && ((^parityBits) ^ parityType);

    apbDone    = psel && penable && r.ready && (r.apbState == APB_DONE);
    statusRead = apbDone && !pwrite && (regIndex(paddr) == 2'h0);
    dataRead   = apbDone && !pwrite && (regIndex(paddr) == 2'h1);
    ctrlWrite  = apbDone && pwrite && (regIndex(paddr) == 2'h2);

    // Sticky flags clear only if seen set by the earlier status read; noise and parity clear after any status read.
    clearFull    = dataRead && r.seenFull;
    clearIdle    = dataRead && r.seenIdle;
    clearOverrun = dataRead && r.seenOverrun;
    clearFraming = dataRead && r.seenFraming;
    clearSoft    = dataRead && r.statusArmed;

    flagsNow = 6'h00;
    flagsNow[URXSF_FULL_BIT]    = r.fullFlag;
    flagsNow[URXSF_IDLE_BIT]    = r.idleFlag;
    flagsNow[URXSF_OVERRUN_BIT] = r.overrunFlag;
    flagsNow[URXSF_NOISE_BIT]   = r.noiseFlag;
    flagsNow[URXSF_FRAMING_BIT] = r.framingFlag;
    flagsNow[URXSF_PARITY_BIT]  = r.parityFlag;
  end

  always_comb begin
    n = r;

    n.rxMeta  = rxPin;
    n.rxLevel = r.rxMeta;

    if (bitTick) begin
      if (!r.rxLevel) begin
        n.idleCount = 4'h0;
      // A count left above a shorter limit holds rather than wrapping round.
      end else if (r.idleCount < idleLimit) begin
        n.idleCount = r.idleCount + 4'h1;
      end
    end

    // Set wins over clear on every flag below.
    n.fullFlag = (r.fullFlag && !clearFull) || loadEvent;
    n.overrunFlag = (r.overrunFlag && !clearOverrun) || overrunEvent;
    n.noiseFlag = (r.noiseFlag && !clearSoft) || (loadEvent && frameNoise);
    n.framingFlag = (r.framingFlag && !clearFraming)
                    || (loadEvent && !frameStopBit);
    n.parityFlag = (r.parityFlag && !clearSoft) || (loadEvent && parityBad);

    // Overrun drops the new frame and leaves the held word alone.
    if (loadEvent) begin
      n.rxData = frameData;
    end

    n.idleFlag = (r.idleFlag && !clearIdle)
                 || (idleEvent && r.idleArmed && !wakeup);
    if (clearIdle) begin
      n.idleArmed = 1'b0;
    end
    if (loadEvent) begin
      n.idleArmed = 1'b1;
    end

    if (dataRead) begin
      n.seenFull    = 1'b0;
      n.seenIdle    = 1'b0;
      n.seenOverrun = 1'b0;
      n.seenFraming = 1'b0;
      n.statusArmed = 1'b0;
    end
    // Snapshot what software was shown, not what is current now.
    if (statusRead) begin
      n.seenFull    = r.rdata[URXSF_FULL_BIT];
      n.seenIdle    = r.rdata[URXSF_IDLE_BIT];
      n.seenOverrun = r.rdata[URXSF_OVERRUN_BIT];
      n.seenFraming = r.rdata[URXSF_FRAMING_BIT];
      n.statusArmed = 1'b1;
    end

    if (ctrlWrite) begin
      n.ctrl = {4'h0, pwdata[3:0]};
    end

    case (r.apbState)
      APB_WAIT: begin
        if (psel && !penable) begin
          n.ready    = 1'b1;
          n.slverr   = 1'b0;
          n.rdata    = 32'h0000_0000;
          n.apbState = APB_DONE;
          if (regIndex(paddr) == 2'h0) begin
            n.rdata = {26'h000_0000, flagsNow};
          end else if (regIndex(paddr) == 2'h1) begin
            n.rdata = {23'h00_0000, r.rxData};
          end else if (regIndex(paddr) == 2'h2) begin
            n.rdata = {24'h00_0000, r.ctrl};
          end else begin
            n.slverr = 1'b1;
          end
        end
      end
      APB_DONE: begin
        if (apbDone) begin
          n.ready    = 1'b0;
          n.slverr   = 1'b0;
          n.apbState = APB_WAIT;
        end
      end
      default: begin
        n.ready    = 1'b0;
        n.apbState = APB_WAIT;
      end
    endcase

    n.flagsOut[URXSF_FULL_BIT]    = n.fullFlag;
    n.flagsOut[URXSF_IDLE_BIT]    = n.idleFlag;
    n.flagsOut[URXSF_OVERRUN_BIT] = n.overrunFlag;
    n.flagsOut[URXSF_NOISE_BIT]   = n.noiseFlag;
    n.flagsOut[URXSF_FRAMING_BIT] = n.framingFlag;
    n.flagsOut[URXSF_PARITY_BIT]  = n.parityFlag;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r <= STATE_RESET;
    end else if (ce) begin
      r <= n;
    end
  end

  assign prdata      = r.rdata;
  assign pready      = r.ready;
  assign pslverr     = r.slverr;
  assign statusFlags = r.flagsOut;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_status_seen_full;
    ce && statusRead && r.rdata[URXSF_FULL_BIT];
  endsequence

  sequence s_late_overrun;
    ce && dataRead && r.seenFull && !r.seenOverrun && (r.overrunFlag || overrunEvent);
  endsequence

  property p_full_set;
    ce && frameDone && !r.framingFlag && !r.fullFlag |=> r.fullFlag && statusFlags[5];
  endproperty
  a_full_set: assert property (p_full_set) else $error("receive-full not set on load");

  property p_full_clear;
    s_status_seen_full ##[2:3] (ce && dataRead && !loadEvent) |=> !r.fullFlag;
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("receive-full not cleared");

  property p_full_hold;
    ce && r.fullFlag && !(dataRead && r.seenFull) |=> r.fullFlag;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("receive-full lost");

  property p_idle_set;
    ce && bitTick && r.rxLevel && r.idleArmed && !wakeup
      && (r.idleCount == (wordLong ? URXSF_IDLE_LONG : URXSF_IDLE_SHORT) - 4'h1) |=> r.idleFlag;
  endproperty
  a_idle_set: assert property (p_idle_set) else $error("idle flag not set");

  property p_idle_rearm;
    !r.idleArmed |=> !$rose(r.idleFlag);
  endproperty
  a_idle_rearm: assert property (p_idle_rearm) else $error("idle set without frame");

  property p_idle_wake;
    r.ctrl[URXSF_WAKE_BIT] |=> !$rose(r.idleFlag);
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle set under wakeup");

  property p_overrun_set;
    ce && frameDone && !r.framingFlag && r.fullFlag |=> r.overrunFlag && $stable(r.rxData);
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not raised");

  property p_late_overrun;
    s_late_overrun |=> r.overrunFlag && !r.fullFlag;
  endproperty
  a_late_overrun: assert property (p_late_overrun) else $error("late overrun lost");

  property p_errors_on_overrun;
    ce && overrunEvent && !dataRead |=> $stable({r.noiseFlag, r.framingFlag, r.parityFlag});
  endproperty
  a_errors_on_overrun: assert property (p_errors_on_overrun) else $error("error set on overrun");

  property p_framing_block;
    ce && r.framingFlag && frameDone && !dataRead |=> $stable(r.rxData) && $stable(r.overrunFlag);
  endproperty
  a_framing_block: assert property (p_framing_block) else $error("frame taken during error");

  property p_parity_off;
    ce && loadEvent && !r.ctrl[URXSF_PEN_BIT] && !r.parityFlag |=> !r.parityFlag;
  endproperty
  a_parity_off: assert property (p_parity_off) else $error("parity error while disabled");

  property p_soft_clear;
    ce && dataRead && r.statusArmed && !loadEvent |=> !r.noiseFlag && !r.parityFlag;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("noise or parity not cleared");

  property p_noise_set;
    ce && loadEvent && frameNoise |=> r.noiseFlag ##1 (r.noiseFlag || $past(dataRead));
  endproperty
  a_noise_set: assert property (p_noise_set) else $error("noise flag not set");

  property p_overrun_clear;
    ce && dataRead && r.seenOverrun && !overrunEvent |=> !r.overrunFlag;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared");

  property p_overrun_hold;
    ce && r.overrunFlag && !(dataRead && r.seenOverrun) |=> r.overrunFlag;
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("overrun lost");

  property p_idle_clear;
    ce && dataRead && r.seenIdle && !loadEvent && !idleEvent |=> !r.idleFlag && !r.idleArmed;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle flag not cleared");

  property p_framing_set;
    ce && loadEvent && !frameStopBit |=> r.framingFlag;
  endproperty
  a_framing_set: assert property (p_framing_set) else $error("framing error not set");

  property p_framing_clear;
    ce && dataRead && r.seenFraming |=> !r.framingFlag;
  endproperty
  a_framing_clear: assert property (p_framing_clear) else $error("framing not cleared");

  property p_framing_hold;
    ce && r.framingFlag && !(dataRead && r.seenFraming) |=> r.framingFlag;
  endproperty
  a_framing_hold: assert property (p_framing_hold) else $error("framing error lost");

  property p_parity_set;
    ce && loadEvent && r.ctrl[URXSF_PEN_BIT]
      && ((wordLong ? ^frameData : ^frameData[7:0]) != r.ctrl[URXSF_PTYPE_BIT]) |=> r.parityFlag;
  endproperty
  a_parity_set: assert property (p_parity_set) else $error("parity error not set");

  property p_load_data;
    ce && loadEvent |=> r.rxData == $past(frameData);
  endproperty
  a_load_data: assert property (p_load_data) else $error("frame not loaded");

  property p_errors_with_full;
    $rose(r.noiseFlag) || $rose(r.framingFlag) || $rose(r.parityFlag) |-> $rose(r.fullFlag);
  endproperty
  a_errors_with_full: assert property (p_errors_with_full) else $error("error flag set alone");

  property p_reset_zero;
    @(posedge clk) disable iff (1'b0)
      !resetn |=> statusFlags == 6'h00 && prdata == 32'h0000_0000 && !pready && !pslverr;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not zero after reset");

endmodule

// ---- verif/urxsf_remote_tx.sv ----
// Purpose: Remote serial transmitter with the sampler results it causes.
// Assumes: One bit time is eight clk cycles; the line idles high.
// Notes:   Frame results read inverted outside the done pulse so stale data never matches.
`timescale 1ns/1ns
module urxsf_remote_tx (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       len,
  input  wire logic       runTicks,
  input  wire logic [8:0] dat,
  input  wire logic       nz,
  input  wire logic       stp,
  output logic            rxPin = 1'b1,
  output logic            bitTick,
  output logic            frameDone = 1'b0,
  output logic      [8:0] frameData,
  output logic            frameNoise,
  output logic            frameStopBit
);
  logic [2:0] phase = 3'h0;
  int         idx   = -1;
  int         last;
  assign last         = len ? 11 : 10;
  assign bitTick      = (phase == 3'h7) && (idx >= 0 || runTicks);
  assign frameData    = frameDone ? (len ? dat : {1'b0, dat[7:0]}) : ~dat;
  assign frameNoise   = frameDone ? nz : ~nz;
  assign frameStopBit = frameDone ? stp : ~stp;
  always @(posedge clk) begin
    phase <= phase + 3'h1;
    frameDone <= bitTick && (idx == last);
    if (idx < 0 && go) begin
      idx <= 0;
    end
    if (bitTick && idx >= 0) begin
      if (idx == last) begin
        rxPin <= 1'b1;
        idx <= -1;
      end else begin
        rxPin <= (idx == 0) ? 1'b0 : (idx == last - 1) ? stp : dat[idx-1];
        idx <= idx + 1;
      end
    end
  end
endmodule

// ---- verif/urxsf_receive_status_tb.sv ----
// Purpose: Self-checking bench for the receive status flags against a bench model.
// Assumes: APB answers when pready is sampled high; flags update one cycle after a frame.
// Notes:   Random frame data keeps bit 7 low so trailing ones never reach the idle count early.
`timescale 1ns/1ns
module urxsf_receive_status_tb;
  import urxsf_pkg::*;
  logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic        go = 0, runTicks = 0, nz = 0, stp = 1, haveSnap = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, rxPin, bitTick, frameDone, frameNoise, frameStopBit;
  logic [8:0]  dat = 9'h000, frameData, dreg = 9'h000;
  logic [5:0]  statusFlags, fl = 6'h00, snap = 6'h00;
  int          errors = 0, checked = 0, seed = 37, armed = 0, ctl = 0;
  urxsf_receive_status i_urxsf_receive_status (.clk, .resetn, .ce(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxPin, .bitTick, .frameDone,
    .frameData, .frameNoise, .frameStopBit, .statusFlags);
  urxsf_remote_tx i_urxsf_remote_tx (.clk, .go, .len(ctl[0]), .runTicks, .dat, .nz, .stp,
    .rxPin, .bitTick, .frameDone, .frameData, .frameNoise, .frameStopBit);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rs;
    apb(URXSF_STATUS_OFS, 1'b0, 32'h0);
    cmp(rd, {26'h0, fl});
    snap = fl;
    haveSnap = 1'b1;
  endtask
  // Sticky flags clear only if the last status read showed them; noise and parity after any status read.
  task automatic rdat;
    apb(URXSF_DATA_OFS, 1'b0, 32'h0);
    cmp(rd, {23'h0, dreg});
    if (haveSnap) begin
      if (snap[4]) armed = 0;
      fl = fl & ~((snap & 6'h3A) | 6'h05);
    end
    haveSnap = 1'b0;
    cmp(statusFlags, fl);
  endtask
  task automatic frame(input logic [8:0] d, input logic n, input logic s);
    logic [8:0] b;
    dat <= d;
    nz <= n;
    stp <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do begin
      @(posedge clk);
    end while (frameDone !== 1'b1);
    b = ctl[0] ? d : {1'b0, d[7:0]};
    if (!fl[1] && fl[5]) fl[3] = 1'b1;
    else if (!fl[1]) begin
      dreg = b;
      armed = 1;
      fl = fl | {1'b1, 2'b00, n, !s, ctl[1] & (^b ^ ctl[2])};
    end
    @(posedge clk);
    cmp(statusFlags, fl);
  endtask
  task automatic idleRun;
    runTicks <= 1'b1;
    repeat (120) @(posedge clk);
    runTicks <= 1'b0;
    if (armed != 0 && !ctl[3]) fl[4] = 1'b1;
    repeat (3) @(posedge clk);
    cmp(statusFlags, fl);
  endtask
  task complete_run;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    cmp(statusFlags, 32'h0);
    apb(8'h0C, 1'b0, 32'h0);
    cmp(err, 1'b1);
    for (int m = 0; m < 8; m++) begin
      ctl = m;
      apb(URXSF_CTRL_OFS, 1'b1, m);
      frame($random(seed) & 9'h17F, m[0], 1'b1);
      rdat;
      rs;
      rdat;
      $display("mode %0d done", m);
    end
    frame(9'h055, 1'b0, 1'b1);
    frame(9'h0AA, 1'b1, 1'b0);
    rs;
    rdat;
    frame(9'h033, 1'b0, 1'b1);
    rs;
    frame(9'h044, 1'b0, 1'b1);
    rdat;
    rs;
    rdat;
    $display("overrun done");
    frame(9'h011, 1'b0, 1'b0);
    frame(9'h022, 1'b0, 1'b1);
    rs;
    rdat;
    $display("framing done");
    idleRun;
    rs;
    frame(9'h066, 1'b0, 1'b1);
    rdat;
    frame(9'h055, 1'b0, 1'b1);
    idleRun;
    ctl = 8;
    apb(URXSF_CTRL_OFS, 1'b1, 32'h8);
    rs;
    rdat;
    frame(9'h066, 1'b0, 1'b1);
    rs;
    rdat;
    idleRun;
    $display("idle done");
    complete_run;
  end
endmodule
